// File: hw/ppi_port_regs.sv
/*
 * One port's interrupt enable, interrupt status and port configuration registers,
 * reached over the serial management pins, with the 10 Mbps loopback path.
 * Assumes MII data and port status arrive on sys_clk; straps and management pins do not.
 */
module ppi_port_regs #(
	parameter logic [4:0] PHY_ADDR = 5'h00,
	parameter logic FIBER_CAPABLE = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	output logic mgmt_irq_out_n,
	// Strap pins
	input wire logic autoneg_enable_pin,
	input wire logic speed_cfg_pin,
	input wire logic scrambler_bypass_strap,
	input wire logic fiber_signal_detect_select,
	// Port core status
	input wire logic [15:0] basic_status,
	input wire logic port_irq_event,
	input wire logic speed_100,
	// Port core controls
	output logic tx_test_en,
	output logic sqe_test_en,
	output logic jabber_en,
	output logic link_test_en,
	output logic scrambler_bypass,
	output logic fiber_sel,
	// MII data side
	input wire logic [3:0] mii_txd,
	input wire logic mii_tx_en,
	input wire logic [3:0] line_rxd,
	input wire logic line_rx_dv,
	input wire logic line_crs,
	output logic [3:0] mii_rxd,
	output logic mii_rx_dv,
	output logic mii_crs
);
	ppi_pkg::ppi_req_t req;
	ppi_pkg::ppi_strap_t strap;
	logic strap_load;
	logic [1:0] ien_r;
	logic [15:0] cfg_r;
	logic [15:0] rd_data_r;
	logic pend_r, pend_nxt, arm_r, pulse_req_r;
	logic irq_set, irq_clr, rd_any, wr_any, glob_en, loop_now;

	// Strap capture after reset release
	ppi_strap_cap u_strap (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.autoneg_enable_pin(autoneg_enable_pin),
		.speed_cfg_pin(speed_cfg_pin),
		.scrambler_bypass_strap(scrambler_bypass_strap),
		.fiber_signal_detect_select(fiber_signal_detect_select),
		.strap(strap),
		.strap_load(strap_load)
	);

	// Serial management frames in and out
	ppi_mdio_slave #(
		.PHY_ADDR(PHY_ADDR)
	) u_mdio (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.mdc(mdc),
		.mdio_in(mdio_in),
		.mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n),
		.req(req),
		.rd_data(rd_data_r),
		.int_pulse_req(pulse_req_r)
	);

	// Request decode
	assign rd_any = req.rd;
	assign wr_any = req.wr;
	assign glob_en = ien_r[ppi_pkg::GLOBAL_IRQ_ENABLE_BIT];

	// Interrupt enable register; only the two defined bits are stored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ien_r <= ppi_pkg::IRQ_ENABLE_RST;
		end else if (wr_any && req.addr == ppi_pkg::REG_IRQ_ENABLE) begin
			ien_r <= req.wdata[1:0] & ppi_pkg::IRQ_ENABLE_WMASK[1:0];
		end
	end

	// Port configuration; straps load once, later writes overwrite them
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= ppi_pkg::PORT_CFG_RST;
		end else begin
			if (strap_load) begin
				cfg_r[ppi_pkg::CFG_LINK_TEST_DISABLE_BIT] <= strap.link_test_dis;
				cfg_r[ppi_pkg::CFG_SCR_BYPASS_BIT] <= strap.scr_bypass;
				cfg_r[ppi_pkg::CFG_FIBER_BIT] <= strap.fiber;
			end
			if (wr_any && req.addr == ppi_pkg::REG_PORT_CFG) begin
				cfg_r <= req.wdata & ppi_pkg::PORT_CFG_WMASK;
			end
		end
	end

	// Pending sources and the ordered clear; a set in the clear cycle wins
	assign irq_set = glob_en & (ien_r[ppi_pkg::TEST_IRQ_FORCE_BIT] | port_irq_event);
	assign irq_clr = rd_any && req.addr == ppi_pkg::REG_IRQ_STATUS && arm_r;
	assign pend_nxt = irq_set | (pend_r & ~irq_clr);

	// Read of basic status arms the clear; any other read disarms it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arm_r <= 1'b0;
		end else if (rd_any) begin
			arm_r <= (req.addr == ppi_pkg::REG_BASIC_STATUS);
		end
	end

	// Pending flag is latching-high
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= 1'b0;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	// Interrupt pin follows pending, but only while interrupts are enabled
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mgmt_irq_out_n <= 1'b1;
		end else begin
			mgmt_irq_out_n <= ~(pend_nxt & glob_en);
		end
	end

	// One data-line pulse per new pending event; repeats would corrupt traffic
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_req_r <= 1'b0;
		end else begin
			pulse_req_r <= pend_nxt & ~pend_r & glob_en & cfg_r[ppi_pkg::CFG_MDIO_IRQ_BIT];
		end
	end

	// Read data are registered; the slave loads them at turnaround
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_r <= 16'h0000;
		end else if (rd_any) begin
			unique case (req.addr)
				ppi_pkg::REG_BASIC_STATUS: rd_data_r <= basic_status;
				ppi_pkg::REG_IRQ_ENABLE: rd_data_r <= {14'h0000, ien_r};
				ppi_pkg::REG_IRQ_STATUS: rd_data_r <= {pend_r, 15'h0000};
				ppi_pkg::REG_PORT_CFG: rd_data_r <= cfg_r & ppi_pkg::PORT_CFG_WMASK;
				default: rd_data_r <= 16'h0000;
			endcase
		end
	end

	// Controls to the port core; 10 Mbps functions only matter outside 100 Mbps
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_test_en <= 1'b0;
			sqe_test_en <= 1'b0;
			jabber_en <= 1'b1;
			link_test_en <= 1'b1;
			scrambler_bypass <= 1'b0;
			fiber_sel <= 1'b0;
		end else begin
			tx_test_en <= cfg_r[ppi_pkg::CFG_TX_TEST_BIT] & speed_100;
			sqe_test_en <= cfg_r[ppi_pkg::CFG_SQE_BIT] & ~speed_100;
			jabber_en <= ~cfg_r[ppi_pkg::CFG_JABBER_DISABLE_BIT];
			link_test_en <= ~cfg_r[ppi_pkg::CFG_LINK_TEST_DISABLE_BIT];
			scrambler_bypass <= cfg_r[ppi_pkg::CFG_SCR_BYPASS_BIT] & speed_100;
			fiber_sel <= cfg_r[ppi_pkg::CFG_FIBER_BIT] & FIBER_CAPABLE;
		end
	end

	// 10 Mbps loopback of the MAC's own transmission
	assign loop_now = mii_tx_en & ~speed_100 & ~cfg_r[ppi_pkg::CFG_LOOP_DISABLE_BIT];

	// Receive pins: looped transmit or line data; carrier covers our own 10 Mbps transmit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mii_rxd <= 4'h0;
			mii_rx_dv <= 1'b0;
			mii_crs <= 1'b0;
		end else begin
			mii_rxd <= loop_now ? mii_txd : line_rxd;
			mii_rx_dv <= loop_now | (line_rx_dv & ~(mii_tx_en & ~speed_100));
			mii_crs <= line_crs | (mii_tx_en & ~speed_100);
		end
	end

	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	a_irq_gate_off:
	assert property (!glob_en && !pend_r && !port_irq_event |=> !pend_r)
		else $error("pending set while interrupts disabled");

	a_pin_gate_off:
	assert property (!glob_en && $past(!glob_en) |-> mgmt_irq_out_n)
		else $error("interrupt pin low while disabled");

	a_test_irq_force:
	assert property (glob_en && ien_r[ppi_pkg::TEST_IRQ_FORCE_BIT] |=> pend_r && !mgmt_irq_out_n)
		else $error("test interrupt did not assert pending and pin");

	a_mdio_pulse_req:
	assert property ($rose(pend_r) && $past(glob_en) && $past(cfg_r[ppi_pkg::CFG_MDIO_IRQ_BIT])
		|-> pulse_req_r)
		else $error("no data-line pulse for new interrupt");

	a_pend_clear:
	assert property (pend_r && irq_clr && !irq_set |=> !pend_r)
		else $error("ordered read did not clear pending");

	a_clear_order:
	assert property ($fell(pend_r) |-> $past(arm_r) && $past(rd_any))
		else $error("pending cleared without status-1 read first");

	a_pend_hold:
	assert property (pend_r && !irq_clr |=> pend_r)
		else $error("pending dropped before ordered read");

	a_loop_data:
	assert property (loop_now |=> mii_rx_dv && mii_crs && mii_rxd == $past(mii_txd))
		else $error("10 Mbps loopback data missing");

	a_loop_block:
	assert property (mii_tx_en && !speed_100 && cfg_r[ppi_pkg::CFG_LOOP_DISABLE_BIT] && !line_rx_dv
		|=> !mii_rx_dv && mii_crs)
		else $error("transmit data leaked with loopback disabled");

	a_strap_link:
	assert property (strap_load && !wr_any |=>
		cfg_r[ppi_pkg::CFG_LINK_TEST_DISABLE_BIT] == $past(strap.link_test_dis))
		else $error("link test bit not loaded from strap");

	a_strap_scr:
	assert property (strap_load && !wr_any |=>
		cfg_r[ppi_pkg::CFG_SCR_BYPASS_BIT] == $past(strap.scr_bypass))
		else $error("scrambler bypass not loaded from strap");

	a_strap_fiber:
	assert property (strap_load && !wr_any |=> cfg_r[ppi_pkg::CFG_FIBER_BIT] == $past(strap.fiber))
		else $error("fiber bit not loaded from strap");

	a_irq_reset_vals:
	assert property (strap_load |-> ien_r == 2'h0 && !pend_r)
		else $error("interrupt bits not zero after reset");

	a_fiber_ignore:
	assert property (fiber_sel == ($past(cfg_r[ppi_pkg::CFG_FIBER_BIT]) && FIBER_CAPABLE))
		else $error("fiber selection does not follow bit and capability");

	// Pin and pulse track pending; a stuck pin would hide every later event
	a_pend_set:
	assert property (irq_set |=> pend_r)
		else $error("interrupt source did not set pending");

	a_pin_assert:
	assert property (glob_en && pend_nxt |=> !mgmt_irq_out_n)
		else $error("interrupt pin not driven low");

	a_pin_release:
	assert property (!pend_nxt |=> mgmt_irq_out_n)
		else $error("interrupt pin low without pending");

	a_pulse_gate:
	assert property (pulse_req_r |-> $past(glob_en) && $past(cfg_r[ppi_pkg::CFG_MDIO_IRQ_BIT]))
		else $error("data-line pulse requested while not enabled");

	// Bits that no strap touches still hold their reset value when straps load
	a_mdio_irq_rst:
	assert property (strap_load |-> !cfg_r[ppi_pkg::CFG_MDIO_IRQ_BIT])
		else $error("data-line interrupt bit not zero after reset");

	a_loop_rst:
	assert property (strap_load |-> !cfg_r[ppi_pkg::CFG_LOOP_DISABLE_BIT])
		else $error("loopback not enabled after reset");

	a_sqe_rst:
	assert property (strap_load |-> !cfg_r[ppi_pkg::CFG_SQE_BIT])
		else $error("sqe bit not zero after reset");

	a_jabber_rst:
	assert property (strap_load |-> !cfg_r[ppi_pkg::CFG_JABBER_DISABLE_BIT])
		else $error("jabber bit not zero after reset");

	// Port-core controls are registered, so each lags its bit by one clock
	a_tx_test_gate:
	assert property (tx_test_en == $past(cfg_r[ppi_pkg::CFG_TX_TEST_BIT] & speed_100))
		else $error("transmit test control wrong");

	a_sqe_gate:
	assert property (sqe_test_en == $past(cfg_r[ppi_pkg::CFG_SQE_BIT] & ~speed_100))
		else $error("sqe control wrong");

	a_jabber_ctl:
	assert property (jabber_en == !$past(cfg_r[ppi_pkg::CFG_JABBER_DISABLE_BIT]))
		else $error("jabber control wrong");

	a_link_ctl:
	assert property (link_test_en == !$past(cfg_r[ppi_pkg::CFG_LINK_TEST_DISABLE_BIT]))
		else $error("link test control wrong");

	a_scr_gate:
	assert property (scrambler_bypass == $past(cfg_r[ppi_pkg::CFG_SCR_BYPASS_BIT] & speed_100))
		else $error("scrambler bypass control wrong");

	a_crs_own_tx:
	assert property (mii_tx_en && !speed_100 |=> mii_crs)
		else $error("carrier missing during own 10 Mbps transmit");
endmodule

// File: hw/ppi_pkg.sv
/*
 * Shared constants and types for the per-port interrupt and configuration registers.
 * Assumes a 10 MHz system clock and a management clock of at most 2.5 MHz.
 */
package ppi_pkg;

	// Management register addresses
	localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
	localparam logic [4:0] REG_IRQ_ENABLE = 5'h11;
	localparam logic [4:0] REG_IRQ_STATUS = 5'h12;
	localparam logic [4:0] REG_PORT_CFG = 5'h13;

	// Field positions
	localparam int GLOBAL_IRQ_ENABLE_BIT = 1;
	localparam int TEST_IRQ_FORCE_BIT = 0;
	localparam int MGMT_IRQ_PENDING_BIT = 15;
	localparam int CFG_TX_TEST_BIT = 14;
	localparam int CFG_MDIO_IRQ_BIT = 12;
	localparam int CFG_LOOP_DISABLE_BIT = 11;
	localparam int CFG_SQE_BIT = 10;
	localparam int CFG_JABBER_DISABLE_BIT = 9;
	localparam int CFG_LINK_TEST_DISABLE_BIT = 8;
	localparam int CFG_SCR_BYPASS_BIT = 3;
	localparam int CFG_FIBER_BIT = 2;

	// Writable bits and reset values; reserved bits hold nothing and read zero
	localparam logic [15:0] IRQ_ENABLE_WMASK = 16'h0003;
	localparam logic [15:0] PORT_CFG_WMASK = 16'h5f0c;
	localparam logic [1:0] IRQ_ENABLE_RST = 2'h0;
	localparam logic [15:0] PORT_CFG_RST = 16'h0000;

	// Management frame framing
	localparam logic [5:0] PREAMBLE_ONES = 6'h20;
	localparam logic [4:0] HDR_LAST = 5'h0c;
	localparam logic [4:0] RD_LAST = 5'h11;
	localparam logic [4:0] WR_LAST = 5'h11;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;

	// Timing: interrupt pulse on the data line, least time, rounded up
	localparam int SYS_CLK_PERIOD_NS = 100;
	localparam int INT_PULSE_NS = 1000;
	localparam logic [3:0] INT_PULSE_CYC =
		4'((INT_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

	// Strap sampling waits for the synchroniser to fill
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_HDR = 4'b0010,
		ST_RD = 4'b0100,
		ST_WR = 4'b1000
	} ppi_mdio_st_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} ppi_req_t;

	typedef struct packed {
		logic link_test_dis;
		logic scr_bypass;
		logic fiber;
	} ppi_strap_t;

endpackage

// File: hw/ppi_strap_cap.sv
/*
 * Captures the configuration pins once after reset release.
 * Assumes the pins are static straps from outside the clock domain.
 */
module ppi_strap_cap (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Strap pins
	input wire logic autoneg_enable_pin,
	input wire logic speed_cfg_pin,
	input wire logic scrambler_bypass_strap,
	input wire logic fiber_signal_detect_select,
	// Captured values
	output ppi_pkg::ppi_strap_t strap,
	output logic strap_load
);
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [1:0] wait_r;
	logic done_r;

	// Two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
		end else begin
			pin_s1 <= {fiber_signal_detect_select, scrambler_bypass_strap, speed_cfg_pin,
				autoneg_enable_pin};
			pin_s2 <= pin_s1;
		end
	end

	// One capture after release, since the async reset may load only constants
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_r <= 2'h0;
			done_r <= 1'b0;
			strap_load <= 1'b0;
			strap <= '0;
		end else begin
			strap_load <= 1'b0;
			if (!done_r) begin
				if (wait_r == ppi_pkg::STRAP_WAIT) begin
					strap_load <= 1'b1;
					done_r <= 1'b1;
					strap.link_test_dis <= ~pin_s2[0] & pin_s2[1];
					strap.scr_bypass <= pin_s2[2];
					strap.fiber <= pin_s2[3];
				end else begin
					wait_r <= wait_r + 2'h1;
				end
			end
		end
	end
endmodule

// File: hw/ppi_mdio_slave.sv
/*
 * Serial management slave: decodes frames, serves reads, sends the interrupt pulse.
 * Assumes MDC at most 2.5 MHz so each MDC half period spans two system clocks.
 */
module ppi_mdio_slave #(
	parameter logic [4:0] PHY_ADDR = 5'h00
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	// Register side
	output ppi_pkg::ppi_req_t req,
	input wire logic [15:0] rd_data,
	input wire logic int_pulse_req
);
	logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2, rise;
	logic [5:0] ones_r;
	logic [4:0] cnt_r;
	logic [15:0] sh_r, rd_sh_r;
	logic [12:0] hdr;
	logic drv_r, pulse_pend_r;
	logic [3:0] pcnt_r;
	ppi_pkg::ppi_mdio_st_t state_r;

	// Synchronisers; mdc_s3 only delays mdc_s2 for edge detection
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2} <= 5'h1f;
		end else begin
			{mdc_s1, mdc_s2, mdc_s3} <= {mdc, mdc_s1, mdc_s2};
			{mdio_s1, mdio_s2} <= {mdio_in, mdio_s1};
		end
	end

	assign rise = mdc_s2 & ~mdc_s3;
	assign hdr = {sh_r[11:0], mdio_s2};

	// Frame decoder; unmatched frames fall back to idle and wait for a preamble
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ppi_pkg::ST_IDLE;
			ones_r <= 6'h00;
			cnt_r <= 5'h00;
			sh_r <= 16'h0000;
			req <= '0;
		end else begin
			req.wr <= 1'b0;
			req.rd <= 1'b0;
			if (rise) begin
				unique case (state_r)
					ppi_pkg::ST_IDLE: begin
						if (mdio_s2) begin
							if (ones_r != ppi_pkg::PREAMBLE_ONES) ones_r <= ones_r + 6'h01;
						end else begin
							if (ones_r == ppi_pkg::PREAMBLE_ONES) state_r <= ppi_pkg::ST_HDR;
							ones_r <= 6'h00;
							cnt_r <= 5'h00;
						end
					end
					ppi_pkg::ST_HDR: begin
						sh_r <= {sh_r[14:0], mdio_s2};
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == ppi_pkg::HDR_LAST) begin
							cnt_r <= 5'h00;
							req.addr <= hdr[4:0];
							state_r <= ppi_pkg::ST_IDLE;
							if (hdr[12] && hdr[9:5] == PHY_ADDR) begin
								if (hdr[11:10] == ppi_pkg::OP_READ) begin
									state_r <= ppi_pkg::ST_RD;
									req.rd <= 1'b1;
								end else if (hdr[11:10] == ppi_pkg::OP_WRITE) begin
									state_r <= ppi_pkg::ST_WR;
								end
							end
						end
					end
					ppi_pkg::ST_RD: begin
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == ppi_pkg::RD_LAST) state_r <= ppi_pkg::ST_IDLE;
					end
					ppi_pkg::ST_WR: begin
						sh_r <= {sh_r[14:0], mdio_s2};
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == ppi_pkg::WR_LAST) begin
							req.wr <= 1'b1;
							req.wdata <= {sh_r[14:0], mdio_s2};
							state_r <= ppi_pkg::ST_IDLE;
						end
					end
				endcase
			end
		end
	end

	// Pin driver: read data after turnaround, else the interrupt pulse when idle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			drv_r <= 1'b0;
			mdio_out <= 1'b0;
			rd_sh_r <= 16'h0000;
			pcnt_r <= 4'h0;
			pulse_pend_r <= 1'b0;
		end else begin
			if (pcnt_r != 4'h0) begin
				pcnt_r <= pcnt_r - 4'h1;
				if (pcnt_r == 4'h1) drv_r <= 1'b0;
			end else if (rise && state_r == ppi_pkg::ST_RD) begin
				if (cnt_r == 5'h00) begin
					drv_r <= 1'b1;
					mdio_out <= 1'b0;
					rd_sh_r <= rd_data;
				end else if (cnt_r == ppi_pkg::RD_LAST) begin
					drv_r <= 1'b0;
				end else begin
					mdio_out <= rd_sh_r[15];
					rd_sh_r <= {rd_sh_r[14:0], 1'b0};
				end
			end else if (pulse_pend_r && state_r == ppi_pkg::ST_IDLE && !drv_r) begin
				drv_r <= 1'b1;
				mdio_out <= 1'b0;
				pcnt_r <= ppi_pkg::INT_PULSE_CYC;
				pulse_pend_r <= 1'b0;
			end
			if (int_pulse_req) pulse_pend_r <= 1'b1;
		end
	end

	assign mdio_oe_n = ~drv_r;
endmodule

// File: sim/ppi_mgmt_model.sv
/*
 * Management station model: drives serial read and write frames on the data line.
 * Assumes the device's active-low drive enable and a pull-up on the shared line.
 */
module ppi_mgmt_model (
	// Clock
	input wire logic sys_clk,
	// Management pins
	output logic mdc,
	output logic mdio_line,
	input wire logic mdio_out,
	input wire logic mdio_oe_n,
	// Read results
	output logic rd_valid,
	output logic [15:0] rd_word,
	output logic rd_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv_en = 1'b0;
	logic drv_val = 1'b1;

	// Line level: device first, then station, else the pull-up
	assign mdio_line = !mdio_oe_n ? mdio_out : (drv_en ? drv_val : 1'b1);

	// Idle: clock stands still low between frames
	initial begin
		mdc = 1'b0;
		rd_valid = 1'b0;
		rd_word = 16'h0000;
		rd_busy = 1'b0;
	end

	// Three system clocks per half period keeps the clock under its top rate
	task automatic half();
		repeat (3) @(negedge sys_clk);
	endtask

	// One whole frame; a read releases the line from the turnaround onward
	task automatic xfer(input logic rd, input logic [4:0] phy, input logic [4:0] reg_a,
			input logic [15:0] wd);
		logic [63:0] f;
		f = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, phy, reg_a, 2'b10, wd};
		rd_busy = 1'b1;
		for (int k = 0; k < 64; k++) begin
			drv_en = !rd || k < 46;
			drv_val = f[63 - k];
			half();
			if (rd && k >= 48)
				rd_word = {rd_word[14:0], mdio_line};
			mdc = 1'b1;
			half();
			mdc = 1'b0;
		end
		drv_en = 1'b0;
		// Let the device's late release land before the frame counts as over
		half();
		rd_busy = 1'b0;
		if (rd) begin
			rd_valid = 1'b1;
			@(negedge sys_clk);
			rd_valid = 1'b0;
		end
	endtask
endmodule

// File: sim/tb_top.sv
/*
 * Self-checking bench for one port's interrupt and configuration registers.
 * Assumes the station model above on the management pins; MII data driven directly.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] PHY = 5'h05;
	logic sys_clk, rst_n, mdc, mdio_line, mdio_out, mdio_oe_n, mgmt_irq_out_n;
	logic autoneg_enable_pin, speed_cfg_pin, scrambler_bypass_strap, fiber_signal_detect_select;
	logic [15:0] basic_status;
	logic port_irq_event, speed_100;
	logic tx_test_en, sqe_test_en, jabber_en, link_test_en, scrambler_bypass, fiber_sel;
	logic [3:0] mii_txd, line_rxd, mii_rxd, exp4;
	logic mii_tx_en, line_rx_dv, line_crs, mii_rx_dv, mii_crs;
	logic rd_valid, rd_busy;
	logic [15:0] rd_word, v, e;
	logic [15:0] pulse_cyc = 16'h0000;
	logic [15:0] lfsr = 16'h5c60;
	logic [15:0] exp_q[$];
	int err_count = 0;
	int samples_checked = 0;

	ppi_port_regs #(.PHY_ADDR(PHY), .FIBER_CAPABLE(1'b1)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
		.mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
		.mgmt_irq_out_n(mgmt_irq_out_n), .autoneg_enable_pin(autoneg_enable_pin),
		.speed_cfg_pin(speed_cfg_pin), .scrambler_bypass_strap(scrambler_bypass_strap),
		.fiber_signal_detect_select(fiber_signal_detect_select), .basic_status(basic_status),
		.port_irq_event(port_irq_event), .speed_100(speed_100), .tx_test_en(tx_test_en),
		.sqe_test_en(sqe_test_en), .jabber_en(jabber_en), .link_test_en(link_test_en),
		.scrambler_bypass(scrambler_bypass), .fiber_sel(fiber_sel), .mii_txd(mii_txd),
		.mii_tx_en(mii_tx_en), .line_rxd(line_rxd), .line_rx_dv(line_rx_dv),
		.line_crs(line_crs), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_crs(mii_crs));

	ppi_mgmt_model u_mgmt (.sys_clk(sys_clk), .mdc(mdc), .mdio_line(mdio_line),
		.mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .rd_valid(rd_valid), .rd_word(rd_word),
		.rd_busy(rd_busy));

	// 10 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Gap after each frame leaves room for the interrupt pulse on the line
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		u_mgmt.xfer(1'b0, PHY, a, d);
		repeat (30) @(negedge sys_clk);
	endtask

	// The expected word is noted first; the monitor compares when the read ends
	task automatic rd(input logic [4:0] a, input logic [15:0] d);
		exp_q.push_back(d);
		u_mgmt.xfer(1'b1, PHY, a, 16'h0000);
		repeat (30) @(negedge sys_clk);
	endtask

	task automatic do_reset(input logic [3:0] s);
		{autoneg_enable_pin, speed_cfg_pin, scrambler_bypass_strap, fiber_signal_detect_select} = s;
		rst_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (10) @(negedge sys_clk);
	endtask

	// Every port-core control against the configuration word
	task automatic cfg_outs(input logic [15:0] c);
		check("tx test", 16'(tx_test_en), 16'(c[14] & speed_100));
		check("sqe", 16'(sqe_test_en), 16'(c[10] & !speed_100));
		check("jabber", 16'(jabber_en), 16'(!c[9]));
		check("link test", 16'(link_test_en), 16'(!c[8]));
		check("scrambler", 16'(scrambler_bypass), 16'(c[3] & speed_100));
		check("fiber", 16'(fiber_sel), 16'(c[2]));
	endtask

	// Read results are taken in order of the notes
	always @(posedge sys_clk) begin
		if (rd_valid) begin
			if (exp_q.size() == 0)
				check("unexpected read", 16'h0001, 16'h0000);
			else
				check("read data", rd_word, exp_q.pop_front());
		end
	end

	// Low drive outside read frames can only be the interrupt pulse
	always @(posedge sys_clk) begin
		if (!mdio_oe_n && !mdio_out && !rd_busy)
			pulse_cyc <= pulse_cyc + 16'h0001;
	end

	// Hang guard, well above the roughly 15000 cycles the tests need
	initial begin
		repeat (40000) @(posedge sys_clk);
		err_count++;
		$display("Watchdog expired");
		tally_and_finish();
	end

	initial begin
		rst_n = 1'b0;
		{autoneg_enable_pin, speed_cfg_pin, scrambler_bypass_strap, fiber_signal_detect_select} = 4'h0;
		basic_status = 16'h7a49;
		port_irq_event = 1'b0;
		speed_100 = 1'b1;
		{mii_txd, line_rxd, mii_tx_en, line_rx_dv, line_crs} = 11'h000;
		// Two strap sets: fixed speed without negotiation, then negotiation with speed_cfg_pin high, bypass and fiber straps low
		for (int i = 0; i < 2; i++) begin
			do_reset(i ? 4'b1100 : 4'b0111);
			e = i ? 16'h0000 : 16'h010c;
			rd(ppi_pkg::REG_PORT_CFG, e);
			rd(ppi_pkg::REG_IRQ_ENABLE, 16'h0000);
			rd(ppi_pkg::REG_IRQ_STATUS, 16'h0000);
			check("irq pin reset", 16'(mgmt_irq_out_n), 16'h0001);
			cfg_outs(e);
		end
		// Boundary word first, then random words at random speed
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			v = (i == 0 ? 16'hffff : lfsr) & ppi_pkg::PORT_CFG_WMASK;
			speed_100 = lfsr[0];
			wr(ppi_pkg::REG_PORT_CFG, v);
			rd(ppi_pkg::REG_PORT_CFG, v);
			cfg_outs(v);
		end
		check("no pulse disabled", pulse_cyc, 16'h0000);
		rd(5'h1f, 16'h0000);
		rd(ppi_pkg::REG_BASIC_STATUS, basic_status);
		// Forced interrupt is ignored without the global enable
		wr(ppi_pkg::REG_PORT_CFG, 16'h1000);
		wr(ppi_pkg::REG_IRQ_ENABLE, 16'h0001);
		check("irq pin masked", 16'(mgmt_irq_out_n), 16'h0001);
		rd(ppi_pkg::REG_IRQ_STATUS, 16'h0000);
		check("no pulse masked", pulse_cyc, 16'h0000);
		wr(ppi_pkg::REG_IRQ_ENABLE, 16'h0003);
		check("irq pin", 16'(mgmt_irq_out_n), 16'h0000);
		check("pulse length", pulse_cyc, 16'(ppi_pkg::INT_PULSE_CYC));
		wr(ppi_pkg::REG_IRQ_ENABLE, 16'h0002);
		// Wrong orders must leave the latched flag set
		rd(ppi_pkg::REG_IRQ_STATUS, 16'h8000);
		rd(ppi_pkg::REG_BASIC_STATUS, basic_status);
		rd(ppi_pkg::REG_IRQ_ENABLE, 16'h0002);
		rd(ppi_pkg::REG_IRQ_STATUS, 16'h8000);
		check("irq pin held", 16'(mgmt_irq_out_n), 16'h0000);
		rd(ppi_pkg::REG_BASIC_STATUS, basic_status);
		rd(ppi_pkg::REG_IRQ_STATUS, 16'h8000);
		rd(ppi_pkg::REG_IRQ_STATUS, 16'h0000);
		check("irq pin cleared", 16'(mgmt_irq_out_n), 16'h0001);
		// A one-cycle core event latches and pulses with only the global enable set
		port_irq_event = 1'b1;
		@(negedge sys_clk);
		port_irq_event = 1'b0;
		repeat (30) @(negedge sys_clk);
		check("event pin", 16'(mgmt_irq_out_n), 16'h0000);
		check("event pulse", pulse_cyc, 16'(2 * ppi_pkg::INT_PULSE_CYC));
		rd(ppi_pkg::REG_BASIC_STATUS, basic_status);
		rd(ppi_pkg::REG_IRQ_STATUS, 16'h8000);
		check("event cleared", 16'(mgmt_irq_out_n), 16'h0001);
		// 10 Mbps transmit with loopback on, then off
		speed_100 = 1'b0;
		for (int i = 0; i < 2; i++) begin
			wr(ppi_pkg::REG_PORT_CFG, i ? 16'h0800 : 16'h0000);
			lfsr = lfsr_next(lfsr);
			mii_txd = lfsr[3:0];
			line_rxd = ~lfsr[3:0];
			exp4 = i ? ~lfsr[3:0] : lfsr[3:0];
			{mii_tx_en, line_rx_dv, line_crs} = 3'b110;
			@(negedge sys_clk);
			check("rxd", {12'h000, mii_rxd}, {12'h000, exp4});
			check("rx_dv", 16'(mii_rx_dv), 16'(!i));
			check("crs", 16'(mii_crs), 16'h0001);
			{mii_tx_en, line_rx_dv} = 2'b00;
		end
		repeat (5) @(negedge sys_clk);
		check("reads pending", 16'(exp_q.size()), 16'h0000);
		tally_and_finish();
	end
endmodule
